// ===== inc/pvcsr_defines.svh
`ifndef PVCSR_DEFINES_SVH
`define PVCSR_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PVCSR_ADDR_INT_CTRL_STAT 5'h1B
`define PVCSR_ADDR_CONTROL_ONE   5'h1E
`define PVCSR_ADDR_CONTROL_TWO   5'h1F

// ----------------------------------------
// field positions
// ----------------------------------------
`define PVCSR_INT_EN_HI          15
`define PVCSR_INT_EN_LO          8
`define PVCSR_INT_ST_HI          7
`define PVCSR_INT_ST_LO          0
`define PVCSR_C1_IND_MODE_HI     15
`define PVCSR_C1_IND_MODE_LO     14
`define PVCSR_C1_POLARITY        13
`define PVCSR_C1_CROSSED         11
`define PVCSR_C1_LOOPBACK        7
`define PVCSR_C2_VARIANT         15
`define PVCSR_C2_PAIR_SELECT     14
`define PVCSR_C2_AUTO_DISABLE    13
`define PVCSR_C2_ENERGY          12
`define PVCSR_C2_FORCE_LINK      11
`define PVCSR_C2_POWER_SAVE      10
`define PVCSR_C2_INT_LEVEL       9
`define PVCSR_C2_JABBER_EN       8
`define PVCSR_C2_ANEG_DONE       7
`define PVCSR_C2_PAUSE           6
`define PVCSR_C2_ISOLATE         5
`define PVCSR_C2_OPMODE_HI       4
`define PVCSR_C2_OPMODE_LO       2
`define PVCSR_C2_LOW_HI          1
`define PVCSR_C2_LOW_LO          0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PVCSR_RST_INT_EN         8'h00
`define PVCSR_RST_INT_ST         8'h00
`define PVCSR_RST_IND_MODE       2'h0
`define PVCSR_RST_VARIANT        1'h1
`define PVCSR_RST_JABBER_EN      1'h1

// ----------------------------------------
// indicator modes
// ----------------------------------------
`define PVCSR_IND_SPEED_LINKACT  2'h0
`define PVCSR_IND_ACT_LINK       2'h1

`endif

// ===== inc/pvcsr_pkg.sv
package pvcsr_pkg;

	// resolved operating mode codes
	typedef enum logic [2:0] {
		OPMODE_NEGOTIATING = 3'b000,
		OPMODE_10_HALF     = 3'b001,
		OPMODE_100_HALF    = 3'b010,
		OPMODE_10_FULL     = 3'b101,
		OPMODE_100_FULL    = 3'b110
	} pvcsr_opmode_type;

	// register access strobe from the management serial engine
	typedef struct packed {
		logic        rdStrobe;
		logic        wrStrobe;
		logic [4:0]  addr;
		logic [15:0] wrData;
	} pvcsr_access_type;

	// one-cycle event pulses, bit order matches status bits 7..0
	typedef struct packed {
		logic jabber;
		logic receiveError;
		logic pageReceived;
		logic parallelFault;
		logic partnerAck;
		logic linkDown;
		logic remoteFault;
		logic linkUp;
	} pvcsr_events_type;

	// live line state from the transceiver core
	typedef struct packed {
		logic             polarityReversed;
		logic             crossed;
		logic             energy;
		logic             anegDone;
		logic             pauseCapable;
		logic             isolate;
		logic             cableConnected;
		logic             linkUp;
		logic             speed100;
		logic             activity;
		pvcsr_opmode_type opMode;
	} pvcsr_status_type;

	// control outputs toward the transceiver core
	typedef struct packed {
		logic remoteLoopback;
		logic crossoverVariantSelect;
		logic pairSelect;
		logic autoCrossoverDisable;
		logic forceLink;
		logic jabberCounterEnable;
	} pvcsr_control_type;

endpackage

// ===== verilog/pvcsr_regs.sv
`timescale 1ns/1ps
`include "pvcsr_defines.svh"
// Behaviour
// - link events interrupt enables, bits 11:8
// - jabber/rxerr/page/fault status, clear on read
// - link events status bits, clear on read
// - indicator mode field selects indicator functions
// - polarity and crossover state read back
// - remote loopback control bit, reset zero
// - crossover variant select, resets to one
// - manual pair mapping when auto disabled
// - disable automatic crossover detection bit
// - energy detect read back
// - force link pass bypasses link control
// - power saving gates receive clock
// - receive clock restarts on link after reconnect
// - interrupt pin polarity select
// - jabber counter enable, resets to one
// - auto-negotiation complete indication
// - pause capability read back
// - isolate mode read back
// - resolved operating mode field
// - upper interrupt enables, bits 15:12
module pvcsr_regs (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        nrst,
	// management register access
	input  wire pvcsr_pkg::pvcsr_access_type access,
	output logic [15:0]                      rdData,
	// core events and state
	input  wire pvcsr_pkg::pvcsr_events_type events,
	input  wire pvcsr_pkg::pvcsr_status_type lineStatus,
	input  wire logic                        rxClockIn,
	// core controls and pins
	output pvcsr_pkg::pvcsr_control_type     control,
	output logic                             receive_clock_output,
	output logic                             indicator_zero,
	output logic                             indicator_one,
	output logic                             intPin
);

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0] intEnable;
	logic [7:0] intStatus;
	logic [1:0] indicatorMode;
	logic       loopback;
	logic       variantSel;
	logic       pairSelect;
	logic       autoDisable;
	logic       forceLink;
	logic       powerSave;
	logic       intLevel;
	logic       jabberEnable;
	logic       rxClockRun;
	logic       intActive;
	logic       wrIntReg;
	logic       wrCtrlOne;
	logic       wrCtrlTwo;
	logic       rdIntReg;

	assign wrIntReg  = access.wrStrobe && (access.addr == `PVCSR_ADDR_INT_CTRL_STAT);
	assign wrCtrlOne = access.wrStrobe && (access.addr == `PVCSR_ADDR_CONTROL_ONE);
	assign wrCtrlTwo = access.wrStrobe && (access.addr == `PVCSR_ADDR_CONTROL_TWO);
	assign rdIntReg  = access.rdStrobe && (access.addr == `PVCSR_ADDR_INT_CTRL_STAT);

	// ----------------------------------------
	// interrupt enables
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			intEnable <= `PVCSR_RST_INT_EN;
		end else if (wrIntReg) begin
			intEnable <= access.wrData[`PVCSR_INT_EN_HI:`PVCSR_INT_EN_LO];
		end
	end

	// ----------------------------------------
	// event status, clear on read
	// ----------------------------------------
	// an event in the read cycle survives the clear so it is never lost
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			intStatus <= `PVCSR_RST_INT_ST;
		end else if (rdIntReg) begin
			intStatus <= events;
		end else begin
			intStatus <= intStatus | events;
		end
	end

	// ----------------------------------------
	// control one
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			indicatorMode <= `PVCSR_RST_IND_MODE;
			loopback      <= 1'h0;
		end else if (wrCtrlOne) begin
			indicatorMode <= access.wrData[`PVCSR_C1_IND_MODE_HI:`PVCSR_C1_IND_MODE_LO];
			loopback      <= access.wrData[`PVCSR_C1_LOOPBACK];
		end
	end

	// ----------------------------------------
	// control two
	// ----------------------------------------
	// completion, pause, isolate and mode are core state; writes to them are dropped
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			variantSel   <= `PVCSR_RST_VARIANT;
			pairSelect   <= 1'h0;
			autoDisable  <= 1'h0;
			forceLink    <= 1'h0;
			powerSave    <= 1'h0;
			intLevel     <= 1'h0;
			jabberEnable <= `PVCSR_RST_JABBER_EN;
		end else if (wrCtrlTwo) begin
			variantSel   <= access.wrData[`PVCSR_C2_VARIANT];
			pairSelect   <= access.wrData[`PVCSR_C2_PAIR_SELECT];
			autoDisable  <= access.wrData[`PVCSR_C2_AUTO_DISABLE];
			forceLink    <= access.wrData[`PVCSR_C2_FORCE_LINK];
			powerSave    <= access.wrData[`PVCSR_C2_POWER_SAVE];
			intLevel     <= access.wrData[`PVCSR_C2_INT_LEVEL];
			jabberEnable <= access.wrData[`PVCSR_C2_JABBER_EN];
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		rdData = 16'h0000;
		case (access.addr)
			`PVCSR_ADDR_INT_CTRL_STAT: begin
				rdData = {intEnable, intStatus};
			end
			`PVCSR_ADDR_CONTROL_ONE: begin
				rdData[`PVCSR_C1_IND_MODE_HI:`PVCSR_C1_IND_MODE_LO] = indicatorMode;
				rdData[`PVCSR_C1_POLARITY] = lineStatus.polarityReversed;
				rdData[`PVCSR_C1_CROSSED]  = lineStatus.crossed;
				rdData[`PVCSR_C1_LOOPBACK] = loopback;
			end
			`PVCSR_ADDR_CONTROL_TWO: begin
				rdData[`PVCSR_C2_VARIANT]      = variantSel;
				rdData[`PVCSR_C2_PAIR_SELECT]  = pairSelect;
				rdData[`PVCSR_C2_AUTO_DISABLE] = autoDisable;
				rdData[`PVCSR_C2_ENERGY]       = lineStatus.energy;
				rdData[`PVCSR_C2_FORCE_LINK]   = forceLink;
				rdData[`PVCSR_C2_POWER_SAVE]   = powerSave;
				rdData[`PVCSR_C2_INT_LEVEL]    = intLevel;
				rdData[`PVCSR_C2_JABBER_EN]    = jabberEnable;
				rdData[`PVCSR_C2_ANEG_DONE]    = lineStatus.anegDone;
				rdData[`PVCSR_C2_PAUSE]        = lineStatus.pauseCapable;
				rdData[`PVCSR_C2_ISOLATE]      = lineStatus.isolate;
				rdData[`PVCSR_C2_OPMODE_HI:`PVCSR_C2_OPMODE_LO] = lineStatus.opMode;
			end
			default: begin
				rdData = 16'h0000;
			end
		endcase
	end

	// ----------------------------------------
	// controls toward the core
	// ----------------------------------------
	// pair select only matters while auto crossover is off; it is masked with the disable bit before the core
	assign control.remoteLoopback         = loopback;
	assign control.crossoverVariantSelect = variantSel;
	assign control.pairSelect             = pairSelect & autoDisable;
	assign control.autoCrossoverDisable   = autoDisable;
	assign control.forceLink              = forceLink;
	assign control.jabberCounterEnable    = jabberEnable;

	// ----------------------------------------
	// receive clock gating
	// ----------------------------------------
	// with power save set, stop on disconnect and restart once reconnected and linked; clearing power save restarts it at once
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rxClockRun <= 1'h1;
		end else if (!powerSave) begin
			rxClockRun <= 1'h1;
		end else if (!lineStatus.cableConnected) begin
			rxClockRun <= 1'h0;
		end else if (lineStatus.linkUp) begin
			rxClockRun <= 1'h1;
		end
	end

	// glitch-free gating would need a latch cell; a plain and is the simple trade here
	assign receive_clock_output = rxClockIn & rxClockRun;

	// ----------------------------------------
	// indicators
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			indicator_zero <= 1'h0;
			indicator_one  <= 1'h0;
		end else begin
			case (indicatorMode)
				`PVCSR_IND_SPEED_LINKACT: begin
					indicator_one  <= lineStatus.speed100;
					indicator_zero <= lineStatus.linkUp | lineStatus.activity;
				end
				`PVCSR_IND_ACT_LINK: begin
					indicator_one  <= lineStatus.activity;
					indicator_zero <= lineStatus.linkUp;
				end
				default: begin
					indicator_one  <= 1'h0;
					indicator_zero <= 1'h0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// interrupt pin
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			intActive <= 1'h0;
		end else begin
			intActive <= |(intStatus & intEnable);
		end
	end

	assign intPin = intLevel ? intActive : ~intActive;

endmodule

// ===== tb/pvcsr_properties.sv
`timescale 1ns/1ps
module pvcsr_properties (
	// clock and reset
	input wire logic                         sys_clk,
	input wire logic                         nrst,
	// register access
	input wire pvcsr_pkg::pvcsr_access_type  access,
	input wire logic [15:0]                  rdData,
	// core side
	input wire pvcsr_pkg::pvcsr_events_type  events,
	input wire pvcsr_pkg::pvcsr_control_type control,
	input wire logic                         intPin
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire onStat = access.addr == 5'h1B;
	wire quiet  = !access.rdStrobe && !access.wrStrobe && events == 8'h00;

	chk_en_write: assert property (access.wrStrobe && onStat |=>
		!onStat || rdData[15:8] == $past(access.wrData[15:8])) else $error("enable bits lost");
	chk_link_set: assert property (events.linkUp |=> !onStat || rdData[0])
		else $error("link up status not set");
	chk_jabber_set: assert property (events.jabber |=> !onStat || rdData[7])
		else $error("jabber status not set");
	chk_read_clear: assert property (access.rdStrobe && onStat && events == 8'h00 |=>
		!onStat || rdData[7:0] == 8'h00) else $error("status kept after read");
	chk_loop_write: assert property (access.wrStrobe && access.addr == 5'h1E |=>
		control.remoteLoopback == $past(access.wrData[7])) else $error("loopback not written");
	chk_pair_gate: assert property (!control.autoCrossoverDisable |-> !control.pairSelect)
		else $error("pair forced while auto");
	chk_pair_write: assert property (access.wrStrobe && access.addr == 5'h1F |=>
		control.pairSelect == ($past(access.wrData[14]) && $past(access.wrData[13])))
		else $error("pair select not written");
	chk_ctl2_write: assert property (access.wrStrobe && access.addr == 5'h1F |=>
		control.forceLink == $past(access.wrData[11]) &&
		control.autoCrossoverDisable == $past(access.wrData[13])) else $error("control two lost");
	chk_reset_vals: assert property ($rose(nrst) |-> control.crossoverVariantSelect &&
		control.jabberCounterEnable && !control.remoteLoopback) else $error("bad reset control");
	chk_int_idle: assert property ($rose(nrst) |-> intPin)
		else $error("interrupt pin not idle high");
	// the pin may only move within three cycles after some access or event
	chk_int_quiet: assert property (quiet [*3] |=> $stable(intPin))
		else $error("interrupt moved unprovoked");
endmodule

bind pvcsr_regs pvcsr_properties i_pvcsr_properties (.sys_clk(sys_clk), .nrst(nrst),
	.access(access), .rdData(rdData), .events(events), .control(control), .intPin(intPin));

// ===== tb/pvcsr_mgmt_master.sv
`timescale 1ns/1ps
module pvcsr_mgmt_master (
	// clock
	input wire logic                    sys_clk,
	// register access
	output pvcsr_pkg::pvcsr_access_type access,
	input wire logic [15:0]             rdData
);
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	initial access = '0;
	// data is inverted on release so a stale word never looks valid
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(negedge sys_clk) access = '{1'h0, 1'h1, a, v};
		@(posedge sys_clk);
		@(negedge sys_clk) access = '{1'h0, 1'h0, a, ~v};
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(negedge sys_clk) access = '{1'h1, 1'h0, a, 16'h0000};
		@(posedge sys_clk) v = rdData;
		@(negedge sys_clk) access = '{1'h0, 1'h0, a, 16'hFFFF};
	endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`define CHK(n,e,g) begin cmpCount++; if ((g) !== (e)) begin errorCnt++; \
	$display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic                         sys_clk = 1'h0;
	logic                         nrst = 1'h0;
	logic                         rxClk = 1'h0;
	pvcsr_pkg::pvcsr_events_type  ev = '0;
	pvcsr_pkg::pvcsr_status_type  ls = '0;
	pvcsr_pkg::pvcsr_access_type  acc;
	pvcsr_pkg::pvcsr_control_type ctl;
	logic [15:0]                  rdData;
	logic                         ind0, ind1, intPin, rxOut;
	int                           errorCnt = 0, cmpCount = 0, rxEdges = 0;
	logic [2:0]                   codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};

	initial forever #20 sys_clk = ~sys_clk;
	always #7 rxClk = ~rxClk;
	always @(posedge rxOut) rxEdges++;

	pvcsr_regs i_pvcsr_regs (.sys_clk(sys_clk), .nrst(nrst), .access(acc), .rdData(rdData),
		.events(ev), .lineStatus(ls), .rxClockIn(rxClk), .control(ctl), .receive_clock_output(rxOut),
		.indicator_zero(ind0), .indicator_one(ind1), .intPin(intPin));
	pvcsr_mgmt_master i_pvcsr_mgmt_master (.sys_clk(sys_clk), .access(acc), .rdData(rdData));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		i_pvcsr_mgmt_master.wr(a, v);
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] v;
		i_pvcsr_mgmt_master.rd(a, v);
		`CHK($sformatf("reg %0h", a), e, v & m)
	endtask
	task automatic pulse(input logic [7:0] b);
		@(negedge sys_clk) ev = b;
		@(negedge sys_clk) ev = '0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#100us;
		errorCnt++;
		print_verdict;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		idle(5);
		nrst = 1'h1;
		rc(5'h1B, 16'hFFFF, 16'h0000);
		rc(5'h1E, 16'hC080, 16'h0000);
		rc(5'h1F, 16'hEF00, 16'h8100);
		for (int i = 0; i < 5; i++) begin
			ls = {{6{i[0]}}, 4'hC, codes[i]};
			rc(5'h1E, 16'h2800, {2'h0, i[0], 1'h0, i[0], 11'h000});
			rc(5'h1F, 16'h10FC, {3'h0, i[0], 4'h0, {3{i[0]}}, codes[i], 2'h0});
		end
		wr(5'h1B, 16'hFF00);
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i);
			idle(1);
			`CHK("intPin", 1'h0, intPin)
			rc(5'h1B, 16'hFFFF, 16'hFF00 | (16'h0001 << i));
			idle(1);
			`CHK("intPin", 1'h1, intPin)
			rc(5'h1B, 16'hFFFF, 16'hFF00);
		end
		wr(5'h1B, 16'hFE00);
		pulse(8'h01);
		idle(2);
		`CHK("intPin", 1'h1, intPin)
		wr(5'h1F, 16'h8300);
		`CHK("intPin", 1'h0, intPin)
		rc(5'h1B, 16'hFFFF, 16'hFE01);
		wr(5'h1B, 16'hFF00);
		pulse(8'h01);
		idle(1);
		`CHK("intPin", 1'h1, intPin)
		rc(5'h1B, 16'hFFFF, 16'hFF01);
		ls = '0;
		wr(5'h1E, 16'hFFFF);
		rc(5'h1E, 16'hE880, 16'hC080);
		wr(5'h1F, 16'hFFFF);
		rc(5'h1F, 16'hFFFC, 16'hEF00);
		`CHK("control", 6'h3F, ctl)
		wr(5'h1F, 16'h4400);
		`CHK("control", 6'h20, ctl)
		idle(3);
		rxEdges = 0;
		idle(8);
		`CHK("rxEdges", 0, rxEdges)
		ls.cableConnected = 1'h1;
		idle(8);
		`CHK("rxEdges", 0, rxEdges)
		ls.linkUp = 1'h1;
		idle(3);
		rxEdges = 0;
		idle(4);
		`CHK("rxRuns", 1'h1, rxEdges > 0)
		wr(5'h1E, 16'h0000);
		idle(2);
		`CHK("indicators", 2'h1, {ind1, ind0})
		ls.linkUp = 1'h0;
		ls.speed100 = 1'h1;
		ls.activity = 1'h1;
		idle(2);
		`CHK("indicators", 2'h3, {ind1, ind0})
		ls.speed100 = 1'h0;
		wr(5'h1E, 16'h4000);
		idle(2);
		`CHK("indicators", 2'h2, {ind1, ind0})
		wr(5'h1E, 16'h8000);
		idle(2);
		`CHK("indicators", 2'h0, {ind1, ind0})
		print_verdict;
	end
endmodule
